//--- core/eac_pkg.sv
// constants and register map of the data memory access control block
// How it works
// - a launched memory write stalls the core exactly two clock cycles
// - a launched memory read stalls the core exactly four clock cycles
// - the arm bit sets only when the same write clears write strobe
// - write strobe reset state is not guaranteed; never rely on it
// - a write lasts 1.9 to 3.4 ms, scaled by oscillator calibration
package eac_pkg;

  // ----------------------------------------------------------------
  // bus and memory shape
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam int          MEM_AW      = 6;
  localparam int          MEM_DEPTH   = 64;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  ADDR_OFS    = 8'h04;
  localparam logic [7:0]  DATA_OFS    = 8'h08;
  localparam logic [7:0]  CAL_OFS     = 8'h0C;

  // ----------------------------------------------------------------
  // control register fields and calibration values
  // ----------------------------------------------------------------
  localparam int          RD_BIT      = 0;
  localparam int          WS_BIT      = 1;
  localparam int          ARM_BIT     = 2;
  localparam logic [7:0]  CAL_RST     = 8'h7F;
  localparam logic [7:0]  CAL_MAX     = 8'hFF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [2:0]  STALL_WR    = 3'h2;
  localparam logic [2:0]  STALL_RD    = 3'h4;
  localparam logic [2:0]  ARM_CYC     = 3'h4;
  localparam int          CLK_KHZ     = 25000;
  localparam int          WR_MIN_US   = 1900;
  localparam int          WR_MAX_US   = 3400;
  // least time rounds up, longest time rounds down
  localparam int          WR_MIN_CYC_DEF = (WR_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int          WR_MAX_CYC_DEF = (WR_MAX_US * CLK_KHZ) / 1000;
  localparam int          WR_CNT_W    = 17;

endpackage

//--- core/eac_mem_if.sv
// link between the access controller and its memory array
`timescale 1ns/1ps
interface eac_mem_if;
  import eac_pkg::*;
  logic               we;
  logic               re;
  logic [MEM_AW-1:0]  addr;
  logic [DATA_W-1:0]  wdata;
  logic [DATA_W-1:0]  rdata;

  modport ctrl_side (output we, output re, output addr, output wdata, input rdata);
  modport mem_side  (input we, input re, input addr, input wdata, output rdata);
endinterface

//--- core/eac_mem.sv
// data memory array with registered read data
`timescale 1ns/1ps
module eac_mem
  import eac_pkg::*;
(
  input  wire logic   i_clk,
  eac_mem_if.mem_side mem
);

  logic [DATA_W-1:0] cell_reg [MEM_DEPTH];
  logic [DATA_W-1:0] rdata_reg;

  // ----------------------------------------------------------------
  // array write and read; cells hold no reset, like real storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (mem.we) begin
      cell_reg[mem.addr] <= mem.wdata;
    end
    if (mem.re) begin
      rdata_reg <= cell_reg[mem.addr];
    end
  end

  assign mem.rdata = rdata_reg;
endmodule

//--- core/eac_top.sv
// data memory access controller: control register, core stall and write timer
`timescale 1ns/1ps
module eac_top
  import eac_pkg::*;
#(
  parameter int WR_MIN_CYC = WR_MIN_CYC_DEF,
  parameter int WR_MAX_CYC = WR_MAX_CYC_DEF
)(
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_cpu_stall,
  output logic                   o_wr_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0]          stall_cnt_reg, stall_cnt_next;
  logic [2:0]          arm_cnt_reg,   arm_cnt_next;
  logic                busy_reg,      busy_next;
  logic [WR_CNT_W-1:0] wr_cnt_reg,    wr_cnt_next;
  logic                rd_pend_reg,   rd_pend_next;
  logic [MEM_AW-1:0]   addr_reg,      addr_next;
  logic [DATA_W-1:0]   data_reg,      data_next;
  logic [DATA_W-1:0]   cal_reg,       cal_next;
  logic [DATA_W-1:0]   rdata_reg,     rdata_next;
  logic                stall_reg;
  logic                ctrl_wr;
  logic                wr_go;
  logic                rd_go;
  logic                armed;
  logic [WR_CNT_W-1:0] wr_dur;

  eac_mem_if mem_bus ();

  eac_mem u_mem (
    .i_clk (i_clk),
    .mem   (mem_bus.mem_side)
  );

  // ----------------------------------------------------------------
  // decode and write duration
  // ----------------------------------------------------------------
  assign ctrl_wr = i_wr && (i_addr == CTRL_OFS);
  assign armed   = (arm_cnt_reg != 3'h0);
  assign wr_go   = ctrl_wr && i_wdata[WS_BIT] && armed && !busy_reg;
  // read launch, refused while a write runs
  assign rd_go   = ctrl_wr && i_wdata[RD_BIT] && !busy_reg && !wr_go;
  // faster oscillator, shorter write; calibration 00 is slowest
  assign wr_dur  = WR_CNT_W'(WR_MIN_CYC + ((int'(CAL_MAX) - int'(cal_reg))
                   * (WR_MAX_CYC - WR_MIN_CYC)) / int'(CAL_MAX));

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    stall_cnt_next = stall_cnt_reg;
    arm_cnt_next   = arm_cnt_reg;
    busy_next      = busy_reg;
    wr_cnt_next    = wr_cnt_reg;
    rd_pend_next   = 1'b0;
    addr_next      = addr_reg;
    data_next      = data_reg;
    cal_next       = cal_reg;
    rdata_next     = rdata_reg;
    mem_bus.we     = 1'b0;
    mem_bus.re     = rd_go;
    mem_bus.addr   = addr_reg;
    mem_bus.wdata  = data_reg;
    // the arm window closes by itself so a stray strobe later cannot write
    if (armed) begin
      arm_cnt_next = arm_cnt_reg - 3'h1;
    end
    if (stall_cnt_reg != 3'h0) begin
      stall_cnt_next = stall_cnt_reg - 3'h1;
    end
    if (wr_go) begin
      stall_cnt_next = STALL_WR;
      arm_cnt_next   = 3'h0;
      busy_next      = 1'b1;
      wr_cnt_next    = wr_dur;
    end else if (ctrl_wr && i_wdata[ARM_BIT] && !i_wdata[WS_BIT]) begin
      // arm only with write strobe written zero
      arm_cnt_next = ARM_CYC;
    end
    if (rd_go) begin
      stall_cnt_next = STALL_RD;
      rd_pend_next   = 1'b1;
    end
    if (busy_reg) begin
      if (wr_cnt_reg == WR_CNT_W'(1)) begin
        // strobe self-clears, cell programmed at the end
        busy_next  = 1'b0;
        mem_bus.we = 1'b1;
      end else begin
        wr_cnt_next = wr_cnt_reg - WR_CNT_W'(1);
      end
    end
    if (rd_pend_reg) begin
      data_next = mem_bus.rdata;
    end
    // address and data are frozen while a write is timed
    if (i_wr && !busy_reg) begin
      if (i_addr == ADDR_OFS) begin
        addr_next = i_wdata[MEM_AW-1:0];
      end
      if (i_addr == DATA_OFS) begin
        data_next = i_wdata;
      end
    end
    if (i_wr && (i_addr == CAL_OFS)) begin
      cal_next = i_wdata;
    end
    if (i_rd) begin
      unique case (i_addr)
        CTRL_OFS: rdata_next = {5'h00, armed, busy_reg, rd_pend_reg};
        ADDR_OFS: rdata_next = {2'h0, addr_reg};
        DATA_OFS: rdata_next = data_reg;
        CAL_OFS:  rdata_next = cal_reg;
        default:  rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stall_cnt_reg <= 3'h0;
      arm_cnt_reg   <= 3'h0;
      // held idle here, but software must not count on it
      busy_reg      <= 1'b0;
      wr_cnt_reg    <= '0;
      rd_pend_reg   <= 1'b0;
      addr_reg      <= '0;
      data_reg      <= '0;
      cal_reg       <= CAL_RST;
      rdata_reg     <= '0;
      stall_reg     <= 1'b0;
    end else begin
      stall_cnt_reg <= stall_cnt_next;
      arm_cnt_reg   <= arm_cnt_next;
      busy_reg      <= busy_next;
      wr_cnt_reg    <= wr_cnt_next;
      rd_pend_reg   <= rd_pend_next;
      addr_reg      <= addr_next;
      data_reg      <= data_next;
      cal_reg       <= cal_next;
      rdata_reg     <= rdata_next;
      stall_reg     <= (stall_cnt_next != 3'h0);
    end
  end

  assign o_rdata     = rdata_reg;
  assign o_cpu_stall = stall_reg;
  assign o_wr_busy   = busy_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [WR_CNT_W-1:0] len_reg;

  // helper: length of the running write in cycles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      len_reg <= '0;
    end else if (busy_reg) begin
      len_reg <= len_reg + WR_CNT_W'(1);
    end else begin
      len_reg <= '0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence wr_stall_s;
    o_cpu_stall [*2] ##1 !o_cpu_stall;
  endsequence

  sequence rd_stall_s;
    o_cpu_stall [*4] ##1 !o_cpu_stall;
  endsequence

  wr_stall_a: assert property (wr_go |=> wr_stall_s)
    else $error("write stall not two cycles");
  rd_stall_a: assert property (rd_go |=> rd_stall_s)
    else $error("read stall not four cycles");
  arm_guard_a: assert property (
    (ctrl_wr && i_wdata[WS_BIT] && i_wdata[ARM_BIT] && !armed) |=> !armed)
    else $error("arm set while strobe written one");
  no_self_wr_a: assert property ((!busy_reg && !wr_go) |=> !o_wr_busy)
    else $error("write started without launch");
  wr_len_a: assert property ($fell(busy_reg) |->
    (int'(len_reg) >= WR_MIN_CYC) && (int'(len_reg) <= WR_MAX_CYC))
    else $error("write duration out of range");
  strobe_clr_a: assert property (
    (busy_reg && wr_cnt_reg == WR_CNT_W'(1)) |-> mem_bus.we ##1 !o_wr_busy)
    else $error("write strobe did not clear at end");

  // the cell and byte being programmed must not move under a timed write
  data_freeze_a: assert property (busy_reg |=> $stable(data_reg) && $stable(addr_reg))
    else $error("address or data moved during a timed write");

  // a read launch is refused while a write is timed
  rd_refuse_a: assert property (
    (ctrl_wr && i_wdata[RD_BIT] && busy_reg) |=> !rd_pend_reg)
    else $error("read launched during a timed write");

  // an arm write with the strobe written zero opens the window
  arm_open_a: assert property (
    (ctrl_wr && i_wdata[ARM_BIT] && !i_wdata[WS_BIT] && !wr_go) |=> armed)
    else $error("arm write did not open the window");

endmodule

//--- testbench/eac_core_model.sv
// processor core model: issues register accesses and waits out its stalls
`timescale 1ns/1ps
module eac_core_model
  import eac_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_stall,
  input  wire logic              i_busy,
  input  wire logic [DATA_W-1:0] i_rdata,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_wdata,
  output logic                   o_wr,
  output logic                   o_rd
);
  int stall_cnt = 0;
  int busy_cnt  = 0;
  // ----------------------------------------------------------------
  // running tallies, so the bench can take differences without races
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_stall === 1'b1) stall_cnt <= stall_cnt + 1;
    if (i_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // a stalled core issues nothing; leading edge leaves a gap between strobes
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    while (i_stall === 1'b1) @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
  endtask
  // read data stands in the one cycle after the read edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_clk);
    while (i_stall === 1'b1) @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule

//--- testbench/eac_top_test.sv
// self-checking bench for the data memory access controller
`timescale 1ns/1ps
module eac_top_test
  import eac_pkg::*;
;
  logic              i_clk;
  logic              i_arst_n;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [DATA_W-1:0] o_rdata;
  logic              o_cpu_stall;
  logic              o_wr_busy;
  logic [DATA_W-1:0] rv;
  int                miscompares = 0;
  int                check_count = 0;
  int                s0;
  int                b0;

  eac_top #(.WR_MIN_CYC(20), .WR_MAX_CYC(40)) u_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cpu_stall(o_cpu_stall),
    .o_wr_busy(o_wr_busy));
  eac_core_model u_core (
    .i_clk(i_clk), .i_stall(o_cpu_stall), .i_busy(o_wr_busy), .i_rdata(o_rdata),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // whole run is a few hundred cycles; this bound is generous
  initial begin
    #(40 * 20000);
    miscompares++;
    stop_test;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    i_arst_n = 1'b0;
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // write strobe reset state is undefined, so stall, calibration and an unmapped read are checked instead
    chk("stall at reset", 0, o_cpu_stall);
    u_core.rd(CAL_OFS, rv);
    chk("cal reset", CAL_RST, rv);
    u_core.rd(8'h10, rv);
    chk("unmapped read", 0, rv);
    $display("test reset done");
    // slowest calibration first, then the reset value; never above nominal
    for (int k = 0; k < 2; k++) begin
      u_core.wr(CAL_OFS, k ? CAL_RST : 8'h00);
      u_core.wr(ADDR_OFS, 8'h03 + k[7:0]);
      u_core.wr(DATA_OFS, 8'h5A ^ k[7:0]);
      s0 = u_core.stall_cnt;
      b0 = u_core.busy_cnt;
      u_core.wr(CTRL_OFS, 8'h04);
      u_core.wr(CTRL_OFS, 8'h02);
      // while timed: data write and read launch refused, strobe bit polls one
      u_core.wr(DATA_OFS, 8'hEE);
      u_core.wr(CTRL_OFS, 8'h01);
      u_core.rd(CTRL_OFS, rv);
      chk("strobe polled", 1, rv[WS_BIT]);
      repeat (200) begin
        @(posedge i_clk);
        if (o_wr_busy === 1'b0) break;
      end
      chk("write stall", 2, u_core.stall_cnt - s0);
      chk("write time", k ? 30 : 40, u_core.busy_cnt - b0);
      chk("busy cleared", 0, o_wr_busy);
      u_core.rd(CTRL_OFS, rv);
      chk("strobe cleared", 0, rv[WS_BIT]);
      u_core.wr(DATA_OFS, 8'hFF);
      s0 = u_core.stall_cnt;
      u_core.wr(CTRL_OFS, 8'h01);
      repeat (6) @(posedge i_clk);
      chk("read stall", 4, u_core.stall_cnt - s0);
      u_core.rd(DATA_OFS, rv);
      chk("read back", 8'h5A ^ k[7:0], rv);
      $display("test write read %0d done", k);
    end
    // arm with strobe set, and strobe without arm, both start nothing
    s0 = u_core.stall_cnt;
    b0 = u_core.busy_cnt;
    u_core.wr(CTRL_OFS, 8'h06);
    u_core.rd(CTRL_OFS, rv);
    chk("no arm", 0, rv[ARM_BIT]);
    u_core.wr(CTRL_OFS, 8'h02);
    repeat (4) @(posedge i_clk);
    chk("refused busy", 0, u_core.busy_cnt - b0);
    chk("refused stall", 0, u_core.stall_cnt - s0);
    $display("test refused arm done");
    stop_test;
  end
endmodule
